// ===== wdt_device.sv
// Operation
// - Counter ticks from 32 kHz, prescaled
// - Prescale code 00/11 /1, 01 /16, 10 /256
// - Control bit 5 enters watchdog mode
// - Watchdog counts load value down to zero
// - Watchdog uses 32 kHz source, 512 s max
// - Expiry: interrupt if bit 1, else reset
// - Service write reloads counter, new timeout
// - Watchdog mode locks load and control writes
// - Normal mode clear write drops interrupt
// - Load and count are 16-bit; count read-only
// - Secure clear demands exact service sequence
// - Sequence from LFSR x8+x6+x5+x+1
// - Seed written to service register beforehand
// - Matching service reloads and advances LFSR
// - Mismatched service resets immediately
// - Zero seed always forces reset
// - LFSR state never readable
// - Control bit 8 selects count up
// - Control bit 7 enables timer
// - Control bit 6 selects periodic mode
`timescale 1ns/100ps
`include "wdt_map.svh"

module wdt_device #(
    parameter int SRC_DIV = `WDT_SRC_CYCLES
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic CLK_EN_IN,
    wdt_if.dev bus
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    generate
        if (SRC_DIV < 1 || SRC_DIV > 65536) begin : g_bad_div
            $error("SRC_DIV out of range");
        end
    endgenerate

    localparam logic [15:0] SRC_LAST = 16'(SRC_DIV - 1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] pre_last(input logic [1:0] code);
        case (code)
            `WDT_PRE_DIV16: pre_last = 8'h0F;
            `WDT_PRE_DIV256: pre_last = 8'hFF;
            default: pre_last = 8'h00;
        endcase
    endfunction

    // Galois form, shifting left
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        lfsr_next = {v[6:0], 1'b0} ^ (v[7] ? `WDT_LFSR_TAPS : 8'h00);
    endfunction

    wdt_pkg::wdt_dev_state_t q, d;

    logic wdog;
    logic src_tick;
    logic tick;
    logic svc_wr;
    logic svc_ok;
    logic terminal;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        wdog = q.ctl[`WDT_CTL_WDOG];
        svc_wr = bus.wr && (bus.addr == `WDT_IDX_CLEAR);
        svc_ok = (bus.wdata[7:0] == q.lfsr) && (q.lfsr != 8'h00);
        src_tick = (q.src_cnt == SRC_LAST);
        tick = 1'b0;
        terminal = 1'b0;

        // 32 kHz source, free running whatever the control bits; held while CLK_EN_IN is low
        d.src_cnt = src_tick ? 16'h0000 : q.src_cnt + 16'h0001;

        if (q.ctl[`WDT_CTL_ENABLE] || wdog) begin
            if (src_tick) begin
                if (q.pre_cnt >= pre_last(q.ctl[`WDT_CTL_PRE_HI:`WDT_CTL_PRE_LO])) begin
                    d.pre_cnt = 8'h00;
                    tick = 1'b1;
                end else begin
                    d.pre_cnt = q.pre_cnt + 8'h01;
                end
            end
        end else begin
            d.pre_cnt = 8'h00;
        end

        // Counting
        if (tick) begin
            if (wdog) begin
                if (q.count == 16'h0000) begin
                    terminal = 1'b1;
                    d.count = q.load;
                end else begin
                    d.count = q.count - 16'h0001;
                end
            end else if (q.ctl[`WDT_CTL_COUNT_UP]) begin
                terminal = (q.count == 16'hFFFF);
                if (terminal && q.ctl[`WDT_CTL_PERIODIC]) begin
                    d.count = q.load;
                end else begin
                    d.count = q.count + 16'h0001;
                end
            end else begin
                terminal = (q.count == 16'h0000);
                if (terminal && q.ctl[`WDT_CTL_PERIODIC]) begin
                    d.count = q.load;
                end else begin
                    d.count = q.count - 16'h0001;
                end
            end
        end

        // Register writes
        if (bus.wr && !wdog) begin
            case (bus.addr)
                `WDT_IDX_LOAD: begin
                    d.load = bus.wdata[15:0];
                    d.count = bus.wdata[15:0];
                end
                `WDT_IDX_CONTROL: begin
                    d.ctl = bus.wdata[8:0] & `WDT_CTL_WRITE_MASK;
                    // Entering watchdog starts a full timeout
                    if (bus.wdata[`WDT_CTL_WDOG]) begin
                        d.count = q.load;
                        d.pre_cnt = 8'h00;
                    end
                end
                default: begin
                end
            endcase
        end

        // Service / clear register
        if (svc_wr) begin
            if (!wdog) begin
                d.irq = 1'b0;
                d.lfsr = bus.wdata[7:0];
            end else if (q.ctl[`WDT_CTL_SECURE]) begin
                if (svc_ok) begin
                    d.count = q.load;
                    d.lfsr = lfsr_next(q.lfsr);
                    d.irq = 1'b0;
                end else begin
                    d.rst_req = 1'b1;
                end
            end else begin
                d.count = q.load;
                d.irq = 1'b0;
            end
        end

        // Expiry beats a same-cycle clear
        if (terminal) begin
            if (!wdog || q.ctl[`WDT_CTL_IRQ_OPT]) begin
                d.irq = 1'b1;
            end else begin
                d.rst_req = 1'b1;
            end
        end

        // Register reads; LFSR deliberately absent
        if (bus.rd) begin
            d.rvalid = 1'b1;
            case (bus.addr)
                `WDT_IDX_LOAD: d.rdata = {16'h0000, q.load};
                `WDT_IDX_VALUE: d.rdata = {16'h0000, q.count};
                `WDT_IDX_CONTROL: d.rdata = {23'h00_0000, q.ctl};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            q <= '0;
            q.load <= `WDT_RST_LOAD;
            q.ctl <= `WDT_RST_CONTROL;
            q.lfsr <= `WDT_RST_LFSR;
        end else if (CLK_EN_IN) begin
            q <= d;
        end
    end

    assign bus.rdata = q.rdata;
    assign bus.rvalid = q.rvalid;
    assign bus.irq = q.irq;
    assign bus.wdog_reset = q.rst_req;

endmodule

// ===== wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define WDT_IDX_LOAD 2'h0
`define WDT_IDX_VALUE 2'h1
`define WDT_IDX_CONTROL 2'h2
`define WDT_IDX_CLEAR 2'h3

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define WDT_CTL_IRQ_OPT 1
`define WDT_CTL_PRE_LO 2
`define WDT_CTL_PRE_HI 3
`define WDT_CTL_SECURE 4
`define WDT_CTL_WDOG 5
`define WDT_CTL_PERIODIC 6
`define WDT_CTL_ENABLE 7
`define WDT_CTL_COUNT_UP 8
`define WDT_CTL_WRITE_MASK 9'h1_FE

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WDT_RST_LOAD 16'h0000
`define WDT_RST_CONTROL 9'h000
`define WDT_RST_LFSR 8'h00

// ----------------------------------------
// Prescale codes and LFSR feedback
// ----------------------------------------
`define WDT_PRE_DIV1 2'h0
`define WDT_PRE_DIV16 2'h1
`define WDT_PRE_DIV256 2'h2
`define WDT_LFSR_TAPS 8'h63

// ----------------------------------------
// Timing: 32.768 kHz source from 250 MHz core clock
// ----------------------------------------
`define WDT_SRC_PERIOD_NS 30518
`define WDT_CORE_PERIOD_NS 4
`define WDT_SRC_CYCLES (`WDT_SRC_PERIOD_NS / `WDT_CORE_PERIOD_NS)
`define WDT_SRC_CNT_W 16

`endif

// ===== wdt_pkg.sv
package wdt_pkg;

    typedef struct packed {
        logic [15:0] load;
        logic [15:0] count;
        logic [8:0] ctl;
        logic [15:0] src_cnt;
        logic [7:0] pre_cnt;
        logic [7:0] lfsr;
        logic irq;
        logic rst_req;
        logic [31:0] rdata;
        logic rvalid;
    } wdt_dev_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [31:0] wdata;
        logic [31:0] rd_data;
        logic rd_valid;
        logic irq;
        logic core_reset;
    } wdt_host_state_t;

endpackage

// ===== wdt_if.sv
`timescale 1ns/100ps

interface wdt_if;
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rvalid;
    logic irq;
    logic wdog_reset;

    modport dev (
        input wr, rd, addr, wdata,
        output rdata, rvalid, irq, wdog_reset
    );

    modport host (
        output wr, rd, addr, wdata,
        input rdata, rvalid, irq, wdog_reset
    );
endinterface

// ===== wdt_host.sv
`timescale 1ns/100ps
`include "wdt_map.svh"

module wdt_host (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic CLK_EN_IN,
    input wire logic CMD_VALID_IN,
    input wire logic CMD_WRITE_IN,
    input wire logic [1:0] CMD_ADDR_IN,
    input wire logic [31:0] CMD_DATA_IN,
    output logic [31:0] RD_DATA_OUT,
    output logic RD_VALID_OUT,
    output logic IRQ_OUT,
    output logic CORE_RESET_OUT,
    wdt_if.host bus
);

    wdt_pkg::wdt_host_state_t q, d;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.wr = CMD_VALID_IN && CMD_WRITE_IN;
        d.rd = CMD_VALID_IN && !CMD_WRITE_IN;
        if (CMD_VALID_IN) begin
            d.addr = CMD_ADDR_IN;
            d.wdata = CMD_DATA_IN;
        end
        d.rd_valid = bus.rvalid;
        if (bus.rvalid) begin
            d.rd_data = bus.rdata;
        end
        d.irq = bus.irq;
        d.core_reset = bus.wdog_reset;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            q <= '0;
        end else if (CLK_EN_IN) begin
            q <= d;
        end
    end

    assign bus.wr = q.wr;
    assign bus.rd = q.rd;
    assign bus.addr = q.addr;
    assign bus.wdata = q.wdata;
    assign RD_DATA_OUT = q.rd_data;
    assign RD_VALID_OUT = q.rd_valid;
    assign IRQ_OUT = q.irq;
    assign CORE_RESET_OUT = q.core_reset;

endmodule

// ===== wdt_asserts.sv
`timescale 1ns/100ps
module wdt_asserts (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic CLK_EN_IN,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [1:0] addr_in,
    input wire logic [31:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic irq_in,
    input wire logic wdog_reset_in
);
    // ----------------------------------------
    // Bus and output relations
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    property p_rd_ans; rd_in && CLK_EN_IN |=> rvalid_in; endproperty
    property p_no_spur; !rd_in |=> !rvalid_in; endproperty
    property p_hold; !rvalid_in |-> $stable(rdata_in); endproperty
    property p_clr0; rd_in && addr_in == 2'h3 |=> rdata_in == 32'h0000_0000; endproperty
    property p_cnt_w; rd_in && !addr_in[1] |=> rdata_in[31:16] == 16'h0000; endproperty
    property p_ctl_w;
        rd_in && addr_in == 2'h2 |=> rdata_in[31:9] == '0 && !rdata_in[0];
    endproperty
    property p_irq_hold; irq_in && !(wr_in && addr_in == 2'h3) |=> irq_in; endproperty
    property p_sticky; wdog_reset_in |=> wdog_reset_in; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_no_spur: assert property (p_no_spur) else $error("stray read valid");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_clr0: assert property (p_clr0) else $error("clear reg readable");
    a_cnt_w: assert property (p_cnt_w) else $error("count too wide");
    a_ctl_w: assert property (p_ctl_w) else $error("control spare bits");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    a_sticky: assert property (p_sticky) else $error("reset request dropped");
    c_irq: cover property ($rose(irq_in));
    c_rst: cover property ($rose(wdog_reset_in));
    c_rd: cover property (rd_in && addr_in == 2'h2);
    c_svc: cover property (wr_in && addr_in == 2'h3);
endmodule

// ===== tb.sv
`timescale 1ns/100ps
module tb;
    logic clk = 0, rst = 1, en = 1, v = 0, w = 0, rv, irq, crst;
    logic [1:0] a = 0;
    logic [31:0] d = 0, rdat;
    int n_mismatch = 0;
    int num_checks = 0;
    wdt_if bus_if();
    wdt_device #(.SRC_DIV(4)) wdt_device_inst (.CORE_CLK_IN(clk), .RST_IN(rst),
        .CLK_EN_IN(en), .bus(bus_if));
    wdt_host wdt_host_inst (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(en),
        .CMD_VALID_IN(v), .CMD_WRITE_IN(w), .CMD_ADDR_IN(a), .CMD_DATA_IN(d),
        .RD_DATA_OUT(rdat), .RD_VALID_OUT(rv), .IRQ_OUT(irq), .CORE_RESET_OUT(crst),
        .bus(bus_if));
    wdt_asserts wdt_asserts_inst (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(en),
        .wr_in(bus_if.wr), .rd_in(bus_if.rd), .addr_in(bus_if.addr),
        .rdata_in(bus_if.rdata), .rvalid_in(bus_if.rvalid), .irq_in(bus_if.irq),
        .wdog_reset_in(bus_if.wdog_reset));
    initial begin
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks, entered at a falling edge
    // ----------------------------------------
    task give_verdict;
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cmd(input logic wi, input logic [1:0] ai, input logic [31:0] di);
        v = 1;
        w = wi;
        a = ai;
        d = di;
        @(negedge clk);
        v = 0;
        @(negedge clk);
    endtask
    task rd(input logic [1:0] ai, output logic [31:0] q);
        cmd(1'h0, ai, 32'h0000_0000);
        for (int i = 0; i < 8 && !rv; i++) @(negedge clk);
        chk(rv, 32'h0000_0001);
        q = rdat;
    endtask
    task tw(input logic sel, input int lim, output int n);
        for (n = 0; n < lim && !(sel ? irq : crst); n++) @(negedge clk);
    endtask
    task do_reset;
        rst = 1;
        repeat (4) @(negedge clk);
        rst = 0;
        @(negedge clk);
    endtask
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], 1'b0} ^ (s[7] ? 8'h63 : 8'h00);
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_rst;
        logic [31:0] q;
        do_reset;
        for (int i = 0; i < 4; i++) begin
            rd(i[1:0], q);
            chk(q, 32'h0000_0000);
        end
    endtask
    task t_pre;
        int n, dv;
        logic [31:0] q;
        for (int c = 0; c < 4; c++) begin
            dv = (c == 1) ? 16 : (c == 2) ? 256 : 1;
            do_reset;
            cmd(1'h1, 2'h0, 32'h0000_0002);
            cmd(1'h1, 2'h2, 32'h0000_0080 | (c << 2));
            tw(1'h1, 5000, n);
            chk(n >= 6 * dv && n <= 12 * dv + 10, 1'h1);
            if (c == 2) begin
                cmd(1'h1, 2'h3, 32'h0000_0000);
                @(negedge clk);
                chk(irq, 1'h0);
                rd(2'h1, q);
                chk(q[15:0], 16'hFFFF);
            end
        end
    endtask
    task t_up;
        int n;
        logic [31:0] q;
        do_reset;
        cmd(1'h1, 2'h0, 32'h0000_FFFD);
        cmd(1'h1, 2'h2, 32'h0000_01C0);
        tw(1'h1, 200, n);
        chk(n < 200, 1'h1);
        rd(2'h1, q);
        chk(q[15:0] >= 16'hFFFD, 1'h1);
    endtask
    // Frozen enable must stop the count; periodic down-count reloads
    task t_frz;
        int n;
        logic [31:0] q;
        do_reset;
        cmd(1'h1, 2'h0, 32'h0000_0002);
        cmd(1'h1, 2'h2, 32'h0000_00C0);
        en = 0;
        repeat (40) @(negedge clk);
        chk(irq, 1'h0);
        en = 1;
        tw(1'h1, 100, n);
        chk(n < 100, 1'h1);
        rd(2'h1, q);
        chk(q[15:0] <= 16'h0002, 1'h1);
    endtask
    task t_wdi;
        int n;
        logic [31:0] q;
        do_reset;
        cmd(1'h1, 2'h0, 32'h0000_0002);
        cmd(1'h1, 2'h2, 32'h0000_0022);
        tw(1'h1, 100, n);
        chk(n < 100, 1'h1);
        chk(crst, 1'h0);
        cmd(1'h1, 2'h0, 32'h0000_0055);
        cmd(1'h1, 2'h2, 32'h0000_0000);
        rd(2'h0, q);
        chk(q, 32'h0000_0002);
        rd(2'h2, q);
        chk(q, 32'h0000_0022);
    endtask
    task t_svc;
        int n;
        do_reset;
        cmd(1'h1, 2'h0, 32'h0000_0008);
        cmd(1'h1, 2'h2, 32'h0000_0020);
        repeat (6) begin
            repeat (20) @(negedge clk);
            cmd(1'h1, 2'h3, 32'h0000_0000);
        end
        chk(crst, 1'h0);
        tw(1'h0, 100, n);
        chk(n < 100, 1'h1);
    endtask
    // Load kept long so that only the service value decides the outcome
    task t_sec(input logic [7:0] seed, input int k, input logic [7:0] bad);
        logic [31:0] q;
        logic [7:0] s;
        do_reset;
        cmd(1'h1, 2'h3, {24'h00_0000, seed});
        rd(2'h3, q);
        chk(q, 32'h0000_0000);
        cmd(1'h1, 2'h0, 32'h0000_0040);
        cmd(1'h1, 2'h2, 32'h0000_0030);
        s = seed;
        repeat (k) begin
            cmd(1'h1, 2'h3, {24'h00_0000, s});
            s = nxt(s);
        end
        chk(crst, 1'h0);
        cmd(1'h1, 2'h3, {24'h00_0000, bad});
        repeat (3) @(negedge clk);
        chk(crst, 1'h1);
    endtask
    initial begin
        t_rst;
        t_pre;
        t_up;
        t_frz;
        t_wdi;
        t_svc;
        t_sec(8'hAA, 3, 8'h66);
        t_sec(8'h00, 0, 8'h00);
        give_verdict;
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        give_verdict;
    end
endmodule
